// ===== hdl/boot_cfg_consts.svh
// Operation
// - Latch vector in cold reset, readback register
// - Bits 3:0 select PLL multiplier code
// - Bits 5:4 divide bus clock for output
// - Bit 6 chooses little or big endian
// - Normal reset holds reset output 4000 cycles
// - Internal source waits 18-bit counter expiry
// - Bits 10:8 select the PCI operating mode
// - PCI enable resets one for modes 1,2
// - Bit 11 set leaves watchdog disabled
`ifndef BOOT_CFG_CONSTS_SVH
`define BOOT_CFG_CONSTS_SVH

// ==========================================================
// Vector field positions
`define VEC_PLL_HI 3
`define VEC_PLL_LO 0
`define VEC_DIV_HI 5
`define VEC_DIV_LO 4
`define VEC_ENDIAN 6
`define VEC_RSTMODE 7
`define VEC_PCI_HI 10
`define VEC_PCI_LO 8
`define VEC_WDOG 11
`define VEC_RSV_HI 15
`define VEC_RSV_LO 12

// ==========================================================
// Field encodings
`define PLL_BYPASS 4'h0
`define PLL_X3 4'h1
`define PLL_X4 4'h2
`define PLL_X8 4'h6
`define PLL_X10A 4'h7
`define PLL_X10B 4'h8
`define DIV_RESERVED 2'h3
`define RSTMODE_NORMAL 1'h0
`define PCI_SAT_TNR 3'h1
`define PCI_SAT_SUSP 3'h2
`define PCI_HOST_RR 3'h5
`define BIG_ENDIAN 1'h1
`define WDOG_DISABLE 1'h1

// ==========================================================
// Timing counts
`define RST_HOLD_CYCLES 13'h0FA0
`define PLL_WAIT_CYCLES 32'h00040000

// ==========================================================
// Register map, byte addresses
`define REG_READBACK 8'h00
`define REG_SETTINGS 8'h04
`define REG_STATUS 8'h08
`define REG_PCI_CTRL 8'h0C
`define REG_WDOG_CTRL 8'h10

// ==========================================================
// Register bit positions
`define PCI_CTRL_EN 0
`define WDOG_CTRL_EN 0
`define ST_PLL_RSV 0
`define ST_DIV_RSV 1
`define ST_RSTMODE_RSV 2
`define ST_PCI_RSV 3
`define ST_LINES_RSV 4
`define ST_PLL_STABLE 5
`define ST_RESET_OUT 6
`define ST_CAPTURED 7

`endif

// ===== hdl/boot_cfg_pkg.sv
package boot_cfg_pkg;

    typedef logic [15:0] boot_vector_t;

    typedef enum logic [1:0] {
        ST_COLD = 2'b00,
        ST_PLL_WAIT = 2'b01,
        ST_RST_HOLD = 2'b10,
        ST_RUN = 2'b11
    } boot_state_e;

endpackage

// ===== hdl/boot_config_vector_decoder.sv
// The implementer's own choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "boot_cfg_consts.svh"

module boot_config_vector_decoder
    import boot_cfg_pkg::*;
#(
    parameter int PLL_WAIT_CYCLES = `PLL_WAIT_CYCLES
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic cold_rst_n_i,
    input wire logic internal_vector_sel_i,
    input wire logic [15:0] boot_vector_lines_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [3:0] pll_mult_o,
    output logic pll_bypass_o,
    output logic pll_stable_o,
    output logic [1:0] ext_div_o,
    output logic ext_clk_tick_o,
    output logic external_clock_out_o,
    output logic big_endian_o,
    output logic [2:0] pci_mode_o,
    output logic pci_host_o,
    output logic pci_enable_o,
    output logic watchdog_enable_o,
    output logic reset_output_n_o,
    output logic reset_output_oe_o
);

    // ==========================================================
    // Decode helpers
    function automatic logic [3:0] pll_factor_f(input logic [3:0] code);
        logic [3:0] f;
        f = 4'h0;
        unique case (code)
            `PLL_X3: f = 4'h3;
            `PLL_X4: f = 4'h4;
            `PLL_X8: f = 4'h8;
            `PLL_X10A: f = 4'hA;
            `PLL_X10B: f = 4'hA;
            default: f = 4'h0;
        endcase
        return f;
    endfunction

    function automatic logic pll_reserved_f(input logic [3:0] code);
        return (code != `PLL_BYPASS) && (pll_factor_f(code) == 4'h0);
    endfunction

    function automatic logic pci_en_default_f(input logic [2:0] mode);
        return (mode == `PCI_SAT_TNR) || (mode == `PCI_SAT_SUSP);
    endfunction

    function automatic logic pci_reserved_f(input logic [2:0] mode);
        return mode > `PCI_HOST_RR;
    endfunction

    // ==========================================================
    // Pin synchronisers
    logic cold_meta;
    logic cold_sync;
    logic cold_sync_d;
    logic sel_meta;
    logic sel_sync;
    boot_vector_t vec_meta;
    boot_vector_t vec_sync;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cold_meta <= 1'b1;
            cold_sync <= 1'b1;
            cold_sync_d <= 1'b1;
        end else begin
            cold_meta <= cold_rst_n_i;
            cold_sync <= cold_meta;
            cold_sync_d <= cold_sync;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sel_meta <= 1'b0;
            sel_sync <= 1'b0;
            vec_meta <= 16'h0000;
            vec_sync <= 16'h0000;
        end else begin
            sel_meta <= internal_vector_sel_i;
            sel_sync <= sel_meta;
            vec_meta <= boot_vector_lines_i;
            vec_sync <= vec_meta;
        end
    end

    // ==========================================================
    // Vector capture at cold reset release
    logic cold_release;
    logic captured;
    logic internal_src;
    boot_vector_t boot_vector_readback;

    // Vector and reset share synchroniser depth, so vec_sync holds the
    // value presented as cold reset rose; idle-high reset avoids a false edge
    assign cold_release = cold_sync && !cold_sync_d;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            boot_vector_readback <= 16'h0000;
            internal_src <= 1'b0;
        end else if (cold_release) begin
            boot_vector_readback <= vec_sync;
            internal_src <= sel_sync;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || !cold_sync) begin
            captured <= 1'b0;
        end else if (cold_release) begin
            captured <= 1'b1;
        end
    end

    // ==========================================================
    // Decoded settings
    logic [3:0] pll_code;
    logic [1:0] div_code;
    logic [2:0] pci_mode;
    logic lines_rsv;

    assign pll_code = boot_vector_readback[`VEC_PLL_HI:`VEC_PLL_LO];
    assign div_code = boot_vector_readback[`VEC_DIV_HI:`VEC_DIV_LO];
    assign pci_mode = boot_vector_readback[`VEC_PCI_HI:`VEC_PCI_LO];
    // Board must keep these low; flagged, never used
    assign lines_rsv = |boot_vector_readback[`VEC_RSV_HI:`VEC_RSV_LO];

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pll_mult_o <= 4'h0;
            pll_bypass_o <= 1'b1;
            ext_div_o <= 2'h0;
            big_endian_o <= 1'b0;
            pci_mode_o <= 3'h0;
            pci_host_o <= 1'b0;
        end else begin
            pll_mult_o <= pll_factor_f(pll_code);
            pll_bypass_o <= (pll_code == `PLL_BYPASS) || pll_reserved_f(pll_code);
            ext_div_o <= div_code;
            big_endian_o <= (boot_vector_readback[`VEC_ENDIAN] == `BIG_ENDIAN);
            pci_mode_o <= pci_reserved_f(pci_mode) ? 3'h0 : pci_mode;
            pci_host_o <= (pci_mode > `PCI_SAT_SUSP) && !pci_reserved_f(pci_mode);
        end
    end

    // ==========================================================
    // Reset sequencer
    boot_state_e state;
    boot_state_e next_state;
    logic [17:0] pll_count;
    logic [12:0] hold_count;
    logic pll_done;
    logic hold_done;

    assign pll_done = (pll_count == 18'(PLL_WAIT_CYCLES - 1));
    assign hold_done = (hold_count == (`RST_HOLD_CYCLES - 13'h0001));

    always_comb begin
        next_state = state;
        unique case (state)
            ST_COLD: begin
                if (cold_release) begin
                    next_state = sel_sync ? ST_PLL_WAIT : ST_RST_HOLD;
                end
            end
            ST_PLL_WAIT: begin
                if (pll_done) begin
                    next_state = ST_RST_HOLD;
                end
            end
            ST_RST_HOLD: begin
                if (hold_done) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                next_state = ST_RUN;
            end
        endcase
        if (!cold_sync) begin
            next_state = ST_COLD;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state <= ST_COLD;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || state != ST_PLL_WAIT) begin
            pll_count <= 18'h00000;
        end else if (!pll_done) begin
            pll_count <= pll_count + 18'h00001;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || state != ST_RST_HOLD) begin
            hold_count <= 13'h0000;
        end else if (!hold_done) begin
            hold_count <= hold_count + 13'h0001;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pll_stable_o <= 1'b0;
        end else begin
            pll_stable_o <= (state == ST_RST_HOLD) || (state == ST_RUN);
        end
    end

    // Open-drain reset pin, pulled low while not running
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            reset_output_oe_o <= 1'b1;
        end else begin
            reset_output_oe_o <= (next_state != ST_RUN);
        end
    end

    assign reset_output_n_o = 1'b0;

    // ==========================================================
    // External clock divider
    ext_clock_divider u_ext_div (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .run_i(pll_stable_o),
        .div_code_i(ext_div_o),
        .tick_o(ext_clk_tick_o),
        .external_clock_out_o(external_clock_out_o)
    );

    // ==========================================================
    // Wishbone slave
    logic req;
    logic wr_fire;
    logic pci_control_register;
    logic watchdog_enable;

    assign req = wb_cyc_i && wb_stb_i;
    assign wr_fire = req && wb_we_i && wb_ack_o && wb_sel_i[0];

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req && !wb_ack_o;
        end
    end

    // Defaults reload from the vector at every cold reset release
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pci_control_register <= 1'b0;
        end else if (cold_release) begin
            pci_control_register <= pci_en_default_f(vec_sync[`VEC_PCI_HI:`VEC_PCI_LO]);
        end else if (wr_fire && wb_adr_i == `REG_PCI_CTRL) begin
            pci_control_register <= wb_dat_i[`PCI_CTRL_EN];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            watchdog_enable <= 1'b0;
        end else if (cold_release) begin
            watchdog_enable <= (vec_sync[`VEC_WDOG] != `WDOG_DISABLE);
        end else if (wr_fire && wb_adr_i == `REG_WDOG_CTRL) begin
            watchdog_enable <= wb_dat_i[`WDOG_CTRL_EN];
        end
    end

    assign pci_enable_o = pci_control_register && (state == ST_RUN);
    assign watchdog_enable_o = watchdog_enable && (state == ST_RUN);

    logic [31:0] status_word;
    logic [31:0] settings_word;

    always_comb begin
        status_word = 32'h00000000;
        status_word[`ST_PLL_RSV] = pll_reserved_f(pll_code);
        status_word[`ST_DIV_RSV] = (div_code == `DIV_RESERVED);
        status_word[`ST_RSTMODE_RSV] =
            (boot_vector_readback[`VEC_RSTMODE] != `RSTMODE_NORMAL);
        status_word[`ST_PCI_RSV] = pci_reserved_f(pci_mode);
        status_word[`ST_LINES_RSV] = lines_rsv;
        status_word[`ST_PLL_STABLE] = pll_stable_o;
        status_word[`ST_RESET_OUT] = reset_output_oe_o;
        status_word[`ST_CAPTURED] = captured;
        settings_word = {16'h0000, internal_src, pci_host_o, pci_mode_o,
            big_endian_o, ext_div_o, pll_bypass_o, 3'h0, pll_mult_o};
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (req && !wb_ack_o) begin
            unique case (wb_adr_i)
                `REG_READBACK: wb_dat_o <= {16'h0000, boot_vector_readback};
                `REG_SETTINGS: wb_dat_o <= settings_word;
                `REG_STATUS: wb_dat_o <= status_word;
                `REG_PCI_CTRL: wb_dat_o <= {31'h00000000, pci_control_register};
                `REG_WDOG_CTRL: wb_dat_o <= {31'h00000000, watchdog_enable};
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end

endmodule

// ===== hdl/ext_clock_divider.sv
`timescale 1ns/1ps
`include "boot_cfg_consts.svh"

module ext_clock_divider (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic [1:0] div_code_i,
    output logic tick_o,
    output logic external_clock_out_o
);

    logic [1:0] count;
    logic [1:0] limit;
    logic hit;

    // ==========================================================
    // Divide by 1, 2 or 4 as enable ticks
    always_comb begin
        unique case (div_code_i)
            2'h0: limit = 2'h0;
            2'h1: limit = 2'h1;
            default: limit = 2'h3;
        endcase
    end

    assign hit = run_i && (count == limit) && (div_code_i != `DIV_RESERVED);

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || !run_i || hit) begin
            count <= 2'h0;
        end else begin
            count <= count + 2'h1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            tick_o <= 1'b0;
        end else begin
            tick_o <= hit;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || !run_i) begin
            external_clock_out_o <= 1'b0;
        end else if (hit) begin
            external_clock_out_o <= ~external_clock_out_o;
        end
    end

endmodule

// ===== testbench/boot_config_vector_decoder_monitor.sv
`timescale 1ns/1ps
module boot_config_vector_decoder_monitor #(
    parameter int PLL_WAIT_CYCLES = 32'h00040000
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic cold_rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [3:0] pll_mult_o,
    input wire logic pll_bypass_o,
    input wire logic pll_stable_o,
    input wire logic [1:0] ext_div_o,
    input wire logic big_endian_o,
    input wire logic [2:0] pci_mode_o,
    input wire logic pci_host_o,
    input wire logic pci_enable_o,
    input wire logic watchdog_enable_o,
    input wire logic reset_output_oe_o
);
    int hold_cnt;
    // ====
    // Cycles the reset pin is driven since the cold pin rose
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || !cold_rst_n_i) begin
            hold_cnt <= 0;
        end else if (reset_output_oe_o) begin
            hold_cnt <= hold_cnt + 1;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // ====
    // Checks
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    a_mult_legal: assert property (pll_mult_o inside {4'h0, 4'h3, 4'h4, 4'h8, 4'hA}
        && ((pll_mult_o == 4'h0) == pll_bypass_o)) else $error("bad multiplier");
    a_pci_legal: assert property (pci_mode_o < 3'h6)
        else $error("reserved pci mode shown");
    a_pci_host: assert property (pci_host_o == (pci_mode_o inside {3'h3, 3'h4, 3'h5}))
        else $error("host flag wrong");
    a_en_in_run: assert property (pci_enable_o || watchdog_enable_o
        |-> !reset_output_oe_o && pll_stable_o) else $error("enable before run");
    a_oe_cold: assert property (!cold_rst_n_i [*6] |-> reset_output_oe_o)
        else $error("reset pin not driven in cold reset");
    a_hold_min: assert property ($fell(reset_output_oe_o) |-> hold_cnt >= 4000)
        else $error("reset pin released early");
    a_hold_max: assert property (hold_cnt <= 4000 + PLL_WAIT_CYCLES + 8)
        else $error("reset pin held too long");
    a_keep_cfg: assert property ((cold_rst_n_i && rst_n_i) [*6] |-> $stable(pll_mult_o)
        && $stable(ext_div_o) && $stable(big_endian_o) && $stable(pci_mode_o))
        else $error("settings changed after capture");
endmodule

bind boot_config_vector_decoder boot_config_vector_decoder_monitor #(
    .PLL_WAIT_CYCLES(PLL_WAIT_CYCLES)
) u_mon (.mclk_i, .rst_n_i, .cold_rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .pll_mult_o,
    .pll_bypass_o, .pll_stable_o, .ext_div_o, .big_endian_o, .pci_mode_o, .pci_host_o,
    .pci_enable_o, .watchdog_enable_o, .reset_output_oe_o);

// ===== testbench/boot_config_vector_decoder_test.sv
`timescale 1ns/1ps
module boot_config_vector_decoder_test;
    localparam int PLL_WAIT = 16;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cold_req = 1'b1;
    logic internal_vector_sel_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] rd;
    logic [15:0] vec = 16'h0000;
    logic cold_rst_n_i, wb_ack_o, pll_bypass_o, pll_stable_o, ext_clk_tick_o;
    logic external_clock_out_o, big_endian_o, pci_host_o, pci_enable_o;
    logic watchdog_enable_o, reset_output_n_o, reset_output_oe_o;
    logic [15:0] boot_vector_lines_i;
    logic [31:0] wb_dat_o;
    logic [3:0] pll_mult_o;
    logic [1:0] ext_div_o;
    logic [2:0] pci_mode_o;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [15:0] vectors [8] = '{16'h0000, 16'h0951, 16'h02A2, 16'h0B36,
        16'h0447, 16'h0508, 16'h0609, 16'h0F03};

    always #20 mclk_i = ~mclk_i;

    boot_strap_model u_straps (.mclk_i(mclk_i), .cold_req_i(cold_req), .vector_i(vec),
        .cold_rst_n_o(cold_rst_n_i), .boot_vector_lines_o(boot_vector_lines_i));

    boot_config_vector_decoder #(.PLL_WAIT_CYCLES(PLL_WAIT)) u_dut (.mclk_i, .rst_n_i,
        .cold_rst_n_i, .internal_vector_sel_i, .boot_vector_lines_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pll_mult_o,
        .pll_bypass_o, .pll_stable_o, .ext_div_o, .ext_clk_tick_o, .external_clock_out_o,
        .big_endian_o, .pci_mode_o, .pci_host_o, .pci_enable_o, .watchdog_enable_o,
        .reset_output_n_o, .reset_output_oe_o);

    // ====
    // Tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, seen);
            fail_count++;
        end
    endtask

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
        input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge mclk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do begin
            @(posedge mclk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        check("ack", 32'(n < 20), 32'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    function automatic logic [3:0] exp_mult(input logic [3:0] c);
        case (c)
            4'h1: return 4'h3;
            4'h2: return 4'h4;
            4'h6: return 4'h8;
            4'h7, 4'h8: return 4'hA;
            default: return 4'h0;
        endcase
    endfunction

    task automatic boot(input logic [15:0] v, input logic isel);
        int n = 0;
        int edges = 0;
        int ticks = 0;
        logic prev;
        logic [31:0] exp_word;
        @(posedge mclk_i);
        vec <= v;
        cold_req <= 1'b1;
        internal_vector_sel_i <= isel;
        repeat (8) @(posedge mclk_i);
        cold_req <= 1'b0;
        while (reset_output_oe_o !== 1'b0 && n < 5000) begin
            @(posedge mclk_i);
            n++;
        end
        check("hold", 32'((n >= 4000 + (isel ? PLL_WAIT : 0))
            && (n <= 4008 + (isel ? PLL_WAIT : 0))), 32'h1);
        check("reset_pin", 32'(reset_output_n_o), 32'h0);
        check("pll_stable", 32'(pll_stable_o), 32'h1);
        prev = external_clock_out_o;
        repeat (16) begin
            @(posedge mclk_i);
            edges += int'(external_clock_out_o !== prev);
            ticks += int'(ext_clk_tick_o === 1'b1);
            prev = external_clock_out_o;
        end
        check("ext_toggles", edges, (v[5:4] == 2'h3) ? 0 : 16 >> v[5:4]);
        check("ext_ticks", ticks, (v[5:4] == 2'h3) ? 0 : 16 >> v[5:4]);
        check("div", 32'(ext_div_o), 32'(v[5:4]));
        check("mult", 32'(pll_mult_o), 32'(exp_mult(v[3:0])));
        check("bypass", 32'(pll_bypass_o), 32'(exp_mult(v[3:0]) == 4'h0));
        check("endian", 32'(big_endian_o), 32'(v[6]));
        check("pci_mode", 32'(pci_mode_o), 32'((v[10:8] < 3'h6) ? v[10:8] : 3'h0));
        check("pci_host", 32'(pci_host_o), 32'(v[10:8] inside {3'h3, 3'h4, 3'h5}));
        check("pci_en", 32'(pci_enable_o), 32'(v[10:8] inside {3'h1, 3'h2}));
        check("wdog", 32'(watchdog_enable_o), 32'(!v[11]));
        wb(1'b0, 8'h00, 4'h0, 32'h0, rd);
        check("readback", rd, {16'h0000, v});
        wb(1'b0, 8'h0C, 4'h0, 32'h0, rd);
        check("pci_ctrl", rd, 32'(v[10:8] inside {3'h1, 3'h2}));
        wb(1'b0, 8'h10, 4'h0, 32'h0, rd);
        check("wdog_ctrl", rd, 32'(!v[11]));
        exp_word = {16'h0000, isel, (v[10:8] inside {3'h3, 3'h4, 3'h5}),
            ((v[10:8] < 3'h6) ? v[10:8] : 3'h0), v[6], v[5:4],
            (exp_mult(v[3:0]) == 4'h0), 3'h0, exp_mult(v[3:0])};
        wb(1'b0, 8'h04, 4'h0, 32'h0, rd);
        check("settings", rd, exp_word);
        exp_word = {24'h000000, 4'hA, (v[10:8] > 3'h5), v[7], (v[5:4] == 2'h3),
            ((v[3:0] != 4'h0) && (exp_mult(v[3:0]) == 4'h0))};
        wb(1'b0, 8'h08, 4'h0, 32'h0, rd);
        check("status", rd, exp_word);
        $display("boot %h done", v);
    endtask

    // ====
    // Sequence
    initial begin
        repeat (5) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            boot(vectors[i], i[0]);
        end
        wb(1'b1, 8'h0C, 4'h1, 32'h1, rd);
        wb(1'b1, 8'h0C, 4'h0, 32'h0, rd);
        wb(1'b0, 8'h0C, 4'h0, 32'h0, rd);
        check("pci_ctrl_wr", rd, 32'h1);
        check("pci_en_out", 32'(pci_enable_o), 32'h1);
        wb(1'b1, 8'h00, 4'hF, 32'hFFFF, rd);
        wb(1'b0, 8'h00, 4'h0, 32'h0, rd);
        check("readback_ro", rd, 32'h0F03);
        wb(1'b0, 8'h20, 4'h0, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        $display("register test done");
        test_done();
    end

    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 50000) begin
            fail_count++;
            test_done();
        end
    end
endmodule

// ===== testbench/boot_strap_model.sv
`timescale 1ns/1ps
module boot_strap_model (
    input wire logic mclk_i,
    input wire logic cold_req_i,
    input wire logic [15:0] vector_i,
    output logic cold_rst_n_o,
    output logic [15:0] boot_vector_lines_o
);
    logic [3:0] since_release;
    initial begin
        cold_rst_n_o = 1'b0;
        boot_vector_lines_o = 16'h0000;
        since_release = 4'h0;
    end
    always @(posedge mclk_i) begin
        if (cold_req_i) begin
            cold_rst_n_o <= 1'b0;
            boot_vector_lines_o <= {4'h0, vector_i[11:0]};
            since_release <= 4'h0;
        end else begin
            cold_rst_n_o <= 1'b1;
            if (since_release < 4'h8) begin
                since_release <= since_release + 4'h1;
            end else begin
                boot_vector_lines_o <= ~boot_vector_lines_o;
            end
        end
    end
endmodule
